// *** smso_pkg.sv ***
// Constants and types shared by the service-mode serial override block.
// Assumes a single 250 MHz clock; all pin inputs are asynchronous.
package smso_pkg;

  // Clock and timing
  localparam int CLK_HZ      = 250_000_000;
  localparam int CLK_KHZ     = CLK_HZ / 1000;
  localparam int CTS_MIN_MS  = 100;
  localparam int CTS_MAX_MS  = 500;
  // Least time, so exact multiple is used; stays far below the longest
  localparam int CTS_DLY_CYC = CLK_KHZ * CTS_MIN_MS;
  localparam int PWR_W       = 28;

  // Serial format
  localparam int SVC_BAUD = 38400;
  localparam int CNT_W    = 16;
  localparam int DATA_W   = 8;
  localparam int FIFO_DEP = 8;
  localparam logic [CNT_W-1:0] SVC_BIT_CYC = CNT_W'(CLK_HZ / SVC_BAUD);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Line levels; idle is high so an undriven pulled-up line is idle
  localparam logic LINE_IDLE  = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic LINE_STOP  = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;
  localparam logic PIN_IDLE   = 1'b1;

  typedef enum logic [1:0] {
    PWR_OFF, PWR_WAIT, PWR_GPIO, PWR_READY
  } smso_pwr_e;

  typedef enum logic [2:0] {
    SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
  } smso_ser_e;

endpackage

// *** smso_fifo.sv ***
// Small synchronous FIFO for received bytes.
// Assumes one clock; push and pop may happen in the same cycle.
`timescale 1ns/1ps
module smso_fifo #(
  parameter int WIDTH = smso_pkg::DATA_W,
  parameter int DEPTH = smso_pkg::FIFO_DEP
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } smso_fifo_s;

  smso_fifo_s q;
  smso_fifo_s d;
  logic       push;
  logic       pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes straight from the count, so full and empty are exact
  assign o_in_ready  = (q.cnt != FULL);
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Next state; pointers wrap explicitly so any depth works
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = i_in_data;
      d.wp        = (q.wp == LAST) ? '0 : AW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : AW'(q.rp + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = (AW + 1)'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = (AW + 1)'(q.cnt - 1'b1);
    end
    if (i_reset) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    q <= d;
  end

endmodule

// *** smso_serial_override.sv ***
// Host serial port with startup gating and service-mode override.
// Assumes pins arrive asynchronous to i_mclk; configuration inputs come
// from stored settings on the same clock and are never written here.
`timescale 1ns/1ps

// Function
// R1: Service low forces 38400 8N1 framing.
// R2: Override never alters stored settings or mode.
// R3: Service high restores configured framing.
// R4: Service low forces command set enabled.
// R5: Service input active low, idle high.
// R6: Data and RTS inputs idle high.
// R7: Drive receive data and CTS, active low.
// R8: Enable low keeps serial off, CTS inactive.
// R9: CTS ready 100 to 500 ms after enable.
// R10: GPIOs active before CTS ready.
// R11: Host holds inputs low 80 ms after disable.
module smso_serial_override #(
  parameter int P_CTS_DLY_CYC = smso_pkg::CTS_DLY_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_module_enable_input,
  input  wire logic       i_service_n,
  input  wire logic       i_host_tx_data_in_n,
  input  wire logic       i_host_request_to_send_in_n,
  input  wire logic [15:0] i_cfg_bit_cycles,
  input  wire logic       i_cfg_parity_en,
  input  wire logic       i_cfg_parity_odd,
  input  wire logic       i_cfg_two_stop,
  input  wire logic       i_cfg_cmd_set_en,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output logic            o_rx_parity_err,
  output logic            o_rx_frame_err,
  output logic            o_rx_overrun,
  output logic            o_host_rx_data_out_n,
  output logic            o_host_clear_to_send_out_n,
  output logic            o_service_mode,
  output logic            o_config_command_set_en,
  output logic            o_gpio_active,
  output logic            o_link_ready
);

  typedef struct packed {
    // Two-stage synchronisers for the pins
    logic                                en_s1;
    logic                                en_s2;
    logic                                svc_s1;
    logic                                svc_s2;
    logic                                td_s1;
    logic                                td_s2;
    logic                                rts_s1;
    logic                                rts_s2;
    // Startup sequencing and service mode
    smso_pkg::smso_pwr_e                 pwr;
    logic [smso_pkg::PWR_W-1:0]          pwr_cnt;
    logic                                gpio;
    logic                                svc;
    logic                                cmd_en;
    // Receiver (host to device)
    smso_pkg::smso_ser_e                 rx_st;
    logic [smso_pkg::CNT_W-1:0]          rx_cnt;
    logic [smso_pkg::CNT_W-1:0]          rx_cyc;
    logic [2:0]                          rx_bit;
    logic [smso_pkg::DATA_W-1:0]         rx_sh;
    logic                                rx_pen;
    logic                                rx_podd;
    logic                                rx_pbad;
    logic                                rx_push;
    logic [smso_pkg::DATA_W-1:0]         rx_byte;
    logic                                perr;
    logic                                ferr;
    logic                                ovr;
    // Transmitter (device to host)
    smso_pkg::smso_ser_e                 tx_st;
    logic [smso_pkg::CNT_W-1:0]          tx_cnt;
    logic [smso_pkg::CNT_W-1:0]          tx_cyc;
    logic [2:0]                          tx_bit;
    logic [smso_pkg::DATA_W-1:0]         tx_sh;
    logic                                tx_pen;
    logic                                tx_par;
    logic                                tx_stop2;
    logic                                tx_line;
  } smso_state_s;

  smso_state_s q;
  smso_state_s d;
  logic        link_on;
  logic        rts_on;
  logic        fifo_in_ready;
  logic [smso_pkg::CNT_W-1:0] eff_cyc;
  logic        eff_pen;
  logic        eff_odd;
  logic        eff_stop2;

  // Parity bit of a byte, even or odd sense
  function automatic logic par_bit(input logic [7:0] b, input logic odd);
    par_bit = (^b) ^ odd;
  endfunction

  // Reload value for a bit period counter
  function automatic logic [smso_pkg::CNT_W-1:0] reload(
    input logic [smso_pkg::CNT_W-1:0] cyc);
    reload = smso_pkg::CNT_W'(cyc - 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Effective framing: service mode overrides, storage stays untouched
  always_comb begin
    if (q.svc) begin
      eff_cyc   = smso_pkg::SVC_BIT_CYC; // R1
      eff_pen   = 1'b0;                  // R1
      eff_odd   = 1'b0;
      eff_stop2 = 1'b0;                  // R1
    end else begin
      eff_cyc   = i_cfg_bit_cycles;      // R3
      eff_pen   = i_cfg_parity_en;       // R3
      eff_odd   = i_cfg_parity_odd;
      eff_stop2 = i_cfg_two_stop;        // R3
    end
  end

  assign link_on = (q.pwr == smso_pkg::PWR_READY);
  assign rts_on  = (q.rts_s2 == smso_pkg::PIN_ACTIVE); // R6

  ////////////////////////////////////////////////////////////////////////
  // Next state for synchronisers, startup, receiver and transmitter
  always_comb begin
    d = q;
    d.en_s1   = i_module_enable_input;
    d.en_s2   = q.en_s1;
    d.svc_s1  = i_service_n;
    d.svc_s2  = q.svc_s1;
    d.td_s1   = i_host_tx_data_in_n;
    d.td_s2   = q.td_s1;
    d.rts_s1  = i_host_request_to_send_in_n;
    d.rts_s2  = q.rts_s1;
    d.rx_push = 1'b0;
    d.perr    = 1'b0;
    d.ferr    = 1'b0;
    d.ovr     = 1'b0;

    // Service mode tracks the pin; only framing and command set change
    d.svc    = (q.svc_s2 == smso_pkg::PIN_ACTIVE); // R5
    d.cmd_en = d.svc || i_cfg_cmd_set_en;          // R4 R2

    // Startup: count the settle time, light GPIOs, then allow CTS
    if (!q.en_s2) begin
      d.pwr     = smso_pkg::PWR_OFF; // R8
      d.pwr_cnt = '0;
    end else begin
      unique case (q.pwr)
        smso_pkg::PWR_OFF: begin
          d.pwr     = smso_pkg::PWR_WAIT;
          d.pwr_cnt = '0;
        end
        smso_pkg::PWR_WAIT: begin
          if (q.pwr_cnt == smso_pkg::PWR_W'(P_CTS_DLY_CYC - 1)) begin
            d.pwr = smso_pkg::PWR_GPIO; // R9
          end else begin
            d.pwr_cnt = smso_pkg::PWR_W'(q.pwr_cnt + 1'b1);
          end
        end
        smso_pkg::PWR_GPIO: begin
          d.pwr = smso_pkg::PWR_READY; // R10
        end
        smso_pkg::PWR_READY: begin
          d.pwr = smso_pkg::PWR_READY;
        end
      endcase
    end
    d.gpio = (d.pwr == smso_pkg::PWR_GPIO) ||
             (d.pwr == smso_pkg::PWR_READY); // R10

    // Receiver; framing latched at the start edge so a mode change
    // mid-byte cannot split a character across two rates
    if (q.rx_st != smso_pkg::SER_IDLE && q.rx_cnt != '0) begin
      d.rx_cnt = smso_pkg::CNT_W'(q.rx_cnt - 1'b1);
    end else begin
      unique case (q.rx_st)
        smso_pkg::SER_IDLE: begin
          if (link_on && q.td_s2 == smso_pkg::LINE_START) begin
            d.rx_st   = smso_pkg::SER_START;
            d.rx_cyc  = eff_cyc;
            d.rx_pen  = eff_pen;
            d.rx_podd = eff_odd;
            d.rx_pbad = 1'b0;
            d.rx_cnt  = {1'b0, eff_cyc[smso_pkg::CNT_W-1:1]};
          end
        end
        smso_pkg::SER_START: begin
          // Mid-bit recheck rejects glitches on the line
          d.rx_st  = (q.td_s2 == smso_pkg::LINE_START) ?
                     smso_pkg::SER_DATA : smso_pkg::SER_IDLE;
          d.rx_bit = '0;
          d.rx_cnt = reload(q.rx_cyc);
        end
        smso_pkg::SER_DATA: begin
          d.rx_sh  = {q.td_s2, q.rx_sh[smso_pkg::DATA_W-1:1]};
          d.rx_bit = 3'(q.rx_bit + 1'b1);
          d.rx_cnt = reload(q.rx_cyc);
          if (q.rx_bit == smso_pkg::LAST_BIT) begin
            d.rx_st = q.rx_pen ? smso_pkg::SER_PAR : smso_pkg::SER_STOP;
          end
        end
        smso_pkg::SER_PAR: begin
          d.rx_pbad = (q.td_s2 != par_bit(q.rx_sh, q.rx_podd));
          d.rx_st   = smso_pkg::SER_STOP;
          d.rx_cnt  = reload(q.rx_cyc);
        end
        smso_pkg::SER_STOP: begin
          d.rx_st = smso_pkg::SER_IDLE;
          if (q.td_s2 != smso_pkg::LINE_STOP) begin
            d.ferr = 1'b1;
          end else if (!fifo_in_ready) begin
            d.ovr = 1'b1; // Byte dropped: host ignored CTS
          end else begin
            d.rx_push = 1'b1;
            d.rx_byte = q.rx_sh;
            d.perr    = q.rx_pbad;
          end
        end
        default: begin
          d.rx_st = smso_pkg::SER_IDLE;
        end
      endcase
    end
    if (!link_on) begin
      d.rx_st = smso_pkg::SER_IDLE; // R8
    end

    // Transmitter; new byte only while the host asserts RTS
    if (q.tx_st != smso_pkg::SER_IDLE && q.tx_cnt != '0) begin
      d.tx_cnt = smso_pkg::CNT_W'(q.tx_cnt - 1'b1);
    end else begin
      unique case (q.tx_st)
        smso_pkg::SER_IDLE: begin
          if (o_tx_ready && i_tx_valid) begin
            d.tx_st    = smso_pkg::SER_START;
            d.tx_sh    = i_tx_data;
            d.tx_cyc   = eff_cyc;
            d.tx_pen   = eff_pen;
            d.tx_par   = par_bit(i_tx_data, eff_odd);
            d.tx_stop2 = eff_stop2;
            d.tx_line  = smso_pkg::LINE_START; // R7
            d.tx_cnt   = reload(eff_cyc);
          end
        end
        smso_pkg::SER_START: begin
          d.tx_st   = smso_pkg::SER_DATA;
          d.tx_bit  = '0;
          d.tx_line = q.tx_sh[0];
          d.tx_cnt  = reload(q.tx_cyc);
        end
        smso_pkg::SER_DATA: begin
          d.tx_bit = 3'(q.tx_bit + 1'b1);
          d.tx_sh  = {1'b0, q.tx_sh[smso_pkg::DATA_W-1:1]};
          d.tx_cnt = reload(q.tx_cyc);
          if (q.tx_bit != smso_pkg::LAST_BIT) begin
            d.tx_line = q.tx_sh[1];
          end else if (q.tx_pen) begin
            d.tx_st   = smso_pkg::SER_PAR;
            d.tx_line = q.tx_par;
          end else begin
            d.tx_st   = smso_pkg::SER_STOP;
            d.tx_line = smso_pkg::LINE_STOP;
          end
        end
        smso_pkg::SER_PAR: begin
          d.tx_st   = smso_pkg::SER_STOP;
          d.tx_line = smso_pkg::LINE_STOP;
          d.tx_cnt  = reload(q.tx_cyc);
        end
        smso_pkg::SER_STOP: begin
          if (q.tx_stop2) begin
            d.tx_stop2 = 1'b0;
            d.tx_cnt   = reload(q.tx_cyc);
          end else begin
            d.tx_st = smso_pkg::SER_IDLE;
          end
        end
        default: begin
          d.tx_st = smso_pkg::SER_IDLE;
        end
      endcase
    end
    if (!link_on) begin
      d.tx_st   = smso_pkg::SER_IDLE;  // R8
      d.tx_line = smso_pkg::LINE_IDLE;
    end

    // Synchronous reset: pins assumed idle until sampled
    if (i_reset) begin
      d         = '0;
      d.svc_s1  = smso_pkg::PIN_IDLE;
      d.svc_s2  = smso_pkg::PIN_IDLE;
      d.td_s1   = smso_pkg::LINE_IDLE;
      d.td_s2   = smso_pkg::LINE_IDLE;
      d.rts_s1  = smso_pkg::PIN_IDLE;
      d.rts_s2  = smso_pkg::PIN_IDLE;
      d.tx_line = smso_pkg::LINE_IDLE;
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Received bytes buffered; a full buffer withdraws CTS from the host
  smso_fifo #(
    .WIDTH (smso_pkg::DATA_W),
    .DEPTH (smso_pkg::FIFO_DEP)
  ) u_rx_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset || !link_on),
    .i_in_data   (q.rx_byte),
    .i_in_valid  (q.rx_push),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (o_rx_data),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready)
  );

  // Outputs; CTS is a handshake so it may be combinational
  assign o_tx_ready = link_on && rts_on && (q.tx_st == smso_pkg::SER_IDLE);
  assign o_host_clear_to_send_out_n = (link_on && fifo_in_ready) ?
         smso_pkg::PIN_ACTIVE : smso_pkg::PIN_IDLE; // R7 R8 R9
  assign o_host_rx_data_out_n    = q.tx_line; // R7
  assign o_rx_parity_err         = q.perr;
  assign o_rx_frame_err          = q.ferr;
  assign o_rx_overrun            = q.ovr;
  assign o_service_mode          = q.svc;
  assign o_config_command_set_en = q.cmd_en;
  assign o_gpio_active           = q.gpio;
  assign o_link_ready            = link_on;

endmodule

// *** smso_chk_sva.sv ***
// Port checker for the service-mode serial override block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module smso_chk (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_module_enable_input,
  input wire logic i_service_n,
  input wire logic i_host_request_to_send_in_n,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_host_rx_data_out_n,
  input wire logic o_host_clear_to_send_out_n,
  input wire logic o_service_mode,
  input wire logic o_config_command_set_en,
  input wire logic o_gpio_active,
  input wire logic o_link_ready
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit hand-off: taken byte starts its frame on the next cycle
  sequence s_take;
    i_tx_valid && o_tx_ready;
  endsequence
  sequence s_start;
    !o_host_rx_data_out_n;
  endsequence
  chk_start_bit: assert property (s_take |=> s_start)
    else $error("start bit not sent after take");
  // Two sync stages, the state change, then the line register: five
  // cycles before a frame cut by disable has returned the line to idle
  chk_off_quiet: assert property ((!i_module_enable_input)[*5] |->
    o_host_clear_to_send_out_n && o_host_rx_data_out_n && !o_link_ready)
    else $error("link active while disabled");
  chk_cts_link: assert property (!o_link_ready |->
    o_host_clear_to_send_out_n)
    else $error("clear to send before startup done");
  chk_gpio_first: assert property ($fell(o_host_clear_to_send_out_n) |->
    o_gpio_active && $past(o_gpio_active))
    else $error("clear to send before pins active");
  chk_cmd_forced: assert property (o_service_mode && $past(o_service_mode)
    |-> o_config_command_set_en)
    else $error("command set not forced in service mode");
  chk_svc_enter: assert property ((!i_service_n)[*5] |-> o_service_mode)
    else $error("service mode not entered");
  chk_svc_leave: assert property (i_service_n[*5] |-> !o_service_mode)
    else $error("service mode not left");
  chk_rts_blocks: assert property (i_host_request_to_send_in_n[*3] |->
    !o_tx_ready)
    else $error("transmit ready without request to send");
endmodule

bind smso_serial_override smso_chk u_chk (
  .i_mclk(i_mclk), .i_reset(i_reset),
  .i_module_enable_input(i_module_enable_input), .i_service_n(i_service_n),
  .i_host_request_to_send_in_n(i_host_request_to_send_in_n),
  .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
  .o_host_rx_data_out_n(o_host_rx_data_out_n),
  .o_host_clear_to_send_out_n(o_host_clear_to_send_out_n),
  .o_service_mode(o_service_mode),
  .o_config_command_set_en(o_config_command_set_en),
  .o_gpio_active(o_gpio_active), .o_link_ready(o_link_ready));

// *** smso_host.sv ***
// Host terminal model on the far side of the serial link.
// Assumes the bench sets the bit period; it changes lines after posedge.
`timescale 1ns/1ps
module smso_host #(
  parameter int P_BIT = 16
) (
  input  wire logic i_mclk,
  input  wire logic i_par_en,
  input  wire logic i_from_dev_n,
  output logic      o_to_dev_n,
  output logic      o_rts_n
);
  logic [7:0] rx_byte;
  logic       rx_par;
  int         rx_cnt = 0;

  // Undriven lines read idle high, as through the pull-ups
  initial begin
    o_to_dev_n = 1'b1;
    o_rts_n    = 1'b1;
  end

  task automatic set_rts(input logic v);
    o_rts_n = v;
  endtask

  // Inputs held low after disable, so nothing back-powers the device
  task automatic go_quiet;
    o_to_dev_n = 1'b0;
    o_rts_n    = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One frame: start, data LSB first, parity if on, stop, then idle bit
  task automatic send_byte(input logic [7:0] b, input logic pb,
                           input logic sb);
    logic [10:0] f;
    f = {sb, pb, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || i_par_en) begin
        o_to_dev_n = f[i];
        repeat (P_BIT) @(posedge i_mclk);
        #1;
      end
    end
    o_to_dev_n = 1'b1;
    repeat (P_BIT) @(posedge i_mclk);
    #1;
  endtask

  // Samples on falling clock edges, mid-bit, away from line changes
  always begin
    @(negedge i_from_dev_n);
    repeat (P_BIT / 2) @(negedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (P_BIT) @(negedge i_mclk);
      rx_byte[i] = i_from_dev_n;
    end
    if (i_par_en) begin
      repeat (P_BIT) @(negedge i_mclk);
      rx_par = i_from_dev_n;
    end
    repeat (P_BIT) @(negedge i_mclk);
    rx_cnt++;
  end
endmodule

// *** service_mode_serial_override_test.sv ***
// Self-checking bench for the service-mode serial override block.
// Assumes the host model on the link; startup delay is shortened.
`timescale 1ns/1ps
module service_mode_serial_override_test;
  localparam int          DLY = 20;
  localparam int          BIT = 16;
  localparam logic [15:0] HI  = 16'h0001;
  localparam logic [15:0] LO  = 16'h0000;
  logic       clk = 0, rst = 1, en = 0, svc_n = 1, cmd_en = 0;
  logic       tx_valid = 0, rx_ready = 0;
  logic       par_en = 1, two_stop = 0;
  logic [7:0] tx_data = 8'h00;
  logic       td_n, rts_n, rd_n, cts_n, tx_ready, rx_valid;
  logic [7:0] rx_data;
  logic       perr, ferr, ovr, svc_mode, cmd_set, gpio, link;
  int         error_cnt = 0, n_compared = 0;
  int         ovr_cnt = 0, perr_cnt = 0, ferr_cnt = 0;

  smso_serial_override #(.P_CTS_DLY_CYC(DLY)) u_dut (
    .i_mclk(clk), .i_reset(rst), .i_module_enable_input(en),
    .i_service_n(svc_n), .i_host_tx_data_in_n(td_n),
    .i_host_request_to_send_in_n(rts_n), .i_cfg_bit_cycles(16'h0010),
    .i_cfg_parity_en(par_en), .i_cfg_parity_odd(1'b0),
    .i_cfg_two_stop(two_stop),
    .i_cfg_cmd_set_en(cmd_en), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .i_rx_ready(rx_ready), .o_rx_parity_err(perr), .o_rx_frame_err(ferr),
    .o_rx_overrun(ovr), .o_host_rx_data_out_n(rd_n),
    .o_host_clear_to_send_out_n(cts_n), .o_service_mode(svc_mode),
    .o_config_command_set_en(cmd_set), .o_gpio_active(gpio),
    .o_link_ready(link));
  smso_host #(.P_BIT(BIT)) u_host (.i_mclk(clk), .i_par_en(par_en),
    .i_from_dev_n(rd_n), .o_to_dev_n(td_n), .o_rts_n(rts_n));

  always #2 clk = ~clk;

  // Flag pulses last one cycle, so they are counted, not polled
  always @(posedge clk) begin
    if (ovr === 1'b1) ovr_cnt++;
    if (perr === 1'b1) perr_cnt++;
    if (ferr === 1'b1) ferr_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts cycles to clear to send; g keeps pins state one cycle before
  task automatic wait_cts(output int n, output logic g);
    n = 0;
    while (cts_n !== 1'b0 && n < 200) begin
      g = gpio;
      tick(1);
      n++;
    end
  endtask

  task automatic wait_rx(input int c);
    int k;
    k = 0;
    while (u_host.rx_cnt == c && k < 400) begin
      tick(1);
      k++;
    end
  endtask

  // Hands over one byte and measures its start bit; bit 0 must be 1
  task automatic tx_byte(input logic [7:0] b, output int len);
    int w;
    w = 0;
    tx_data = b;
    tx_valid = 1;
    while (tx_ready !== 1'b1 && w < 200) begin
      tick(1);
      w++;
    end
    tick(1);
    tx_valid = 0;
    while (rd_n !== 1'b0 && w < 210) begin
      tick(1);
      w++;
    end
    len = 0;
    while (rd_n === 1'b0 && len < 7000) begin
      tick(1);
      len++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_startup;
    int   n;
    logic g;
    tick(30);
    check(16'(cts_n), HI);
    check(16'(link), LO);
    en = 1;
    wait_cts(n, g);
    check(16'(n >= DLY && n <= DLY + 8), HI);
    check(16'(g), HI);
  endtask

  task automatic t_tx;
    int len, c;
    tx_valid = 1;
    tick(10);
    check(16'(tx_ready), LO);
    u_host.set_rts(1'b0);
    c = u_host.rx_cnt;
    tx_byte(8'hA5, len);
    check(16'(len), 16'(BIT));
    wait_rx(c);
    check(16'(u_host.rx_byte), 16'h00A5);
    check(16'(u_host.rx_par), LO);
  endtask

  // Host ignores back-pressure on purpose to overflow the buffer
  task automatic t_rx;
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 8'h10 + 8'(i);
      u_host.send_byte(b, ^b, 1'b1);
    end
    tick(4);
    check(16'(cts_n), HI);
    u_host.send_byte(8'h55, 1'b0, 1'b1);
    tick(4);
    check(16'(ovr_cnt), HI);
    rx_ready = 1;
    for (int i = 0; i < 8; i++) begin
      check(16'(rx_data), 16'h0010 + 16'(i));
      tick(1);
    end
    check(16'(rx_valid), LO);
    u_host.send_byte(8'h66, 1'b1, 1'b1);
    u_host.send_byte(8'h77, 1'b0, 1'b0);
    tick(4);
    check(16'(perr_cnt), HI);
    check(16'(ferr_cnt), HI);
  endtask

  // Service frame is cut short by disabling, to keep the run brief;
  // the restored setting then runs without parity and with two stops
  task automatic t_service;
    int   len, c, n, m;
    logic g;
    check(16'(cmd_set), LO);
    svc_n = 0;
    tick(6);
    check(16'(svc_mode), HI);
    check(16'(cmd_set), HI);
    check(16'(link), HI);
    tx_byte(8'hFF, len);
    check(16'(len), smso_pkg::SVC_BIT_CYC);
    en = 0;
    tick(4);
    check(16'(rd_n), HI);
    check(16'(cts_n), HI);
    svc_n = 1;
    cmd_en = 1;
    par_en = 0;
    two_stop = 1;
    en = 1;
    tick(6);
    check(16'(svc_mode), LO);
    check(16'(cmd_set), HI);
    wait_cts(n, g);
    c = u_host.rx_cnt;
    tx_byte(8'h33, len);
    check(16'(len), 16'(BIT));
    // Frame ends after start, eight data and two stop bits
    m = 0;
    while (tx_ready !== 1'b1 && m < 400) begin
      tick(1);
      m++;
    end
    check(16'(len + m), 16'(11 * BIT));
    wait_rx(c);
    check(16'(u_host.rx_byte), 16'h0033);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst = 0;
    t_startup();
    t_tx();
    t_rx();
    t_service();
    en = 0;
    u_host.go_quiet();
    tick(20);
    stop_test();
  end

  // Whole run needs under 10k cycles; this cuts a hang at 50k
  initial begin
    #200_000;
    error_cnt++;
    stop_test();
  end
endmodule
